// File: design/smr_regs.sv
// Serial command port with the mode and supply control register.
`timescale 1ns/1ps
module smr_regs #(
    parameter int unsigned SOFT_RESET_CYCLES = 16
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic sclk_in,
    input wire logic csn_in,
    input wire logic sdi_in,
    output logic sdo_out,
    output logic sdo_oe_out,
    input wire logic restart_in,
    input wire logic overvoltage_in,
    input wire logic overtemperature_in,
    input wire logic soft_reset_output_mask_in,
    input wire logic main_overvoltage_flag_clear_in,
    output logic [1:0] mode_out,
    output logic third_regulator_enable_out,
    output logic [1:0] second_regulator_select_out,
    output logic overvoltage_reaction_enable_out,
    output logic [1:0] reset_threshold_select_out,
    output logic main_overvoltage_flag_out,
    output logic restart_request_out,
    output logic soft_reset_out,
    output logic reset_output_n_out
);
    if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 255) begin : g_bad_cycles
        $error("SOFT_RESET_CYCLES out of range");
    end

    // Chip select leaves reset at its idle high level, so reset release starts no frame.
    localparam logic [5:0] SYNC_IDLE = 6'h10;

    logic [5:0] sync_vec;
    logic sclk_s, csn_s, sdi_s, restart_s, ov_s, ot_s;

    smr_sync #(.WIDTH(6), .RESET_VALUE(SYNC_IDLE)) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .async_in({sclk_in, csn_in, sdi_in, restart_in, overvoltage_in, overtemperature_in}),
        .sync_out(sync_vec)
    );
    assign {sclk_s, csn_s, sdi_s, restart_s, ov_s, ot_s} = sync_vec;

    function automatic logic [7:0] read_value(input logic [6:0] addr, input logic [7:0] reg_val);
        read_value = (addr == smr_pkg::MODE_SUPPLY_CONTROL_ADDR) ? reg_val : smr_pkg::READ_ZERO;
    endfunction : read_value

    typedef enum logic [1:0] {
        SMR_IDLE = 2'b00,
        SMR_SHIFT = 2'b01,
        SMR_DONE = 2'b11
    } smr_state_t;

    smr_state_t state, next_state;
    logic sclk_d, next_sclk_d;
    logic ov_d, next_ov_d;
    logic restart_d, next_restart_d;
    logic [4:0] bit_cnt, next_bit_cnt;
    logic [15:0] rx, next_rx;
    logic [15:0] tx, next_tx;
    logic [7:0] ctrl, next_ctrl;
    logic ov_flag, next_ov_flag;
    logic restart_req, next_restart_req;
    logic soft_rst, next_soft_rst;
    logic rst_out_n, next_rst_out_n;
    logic [7:0] soft_cnt, next_soft_cnt;
    logic sdo, next_sdo;
    logic sdo_oe, next_sdo_oe;
    logic [15:0] frame;
    logic [6:0] f_addr;
    logic f_write;
    logic [7:0] f_data;
    logic [1:0] req_mode;
    logic sclk_rise, sclk_fall, restart_rise, ov_rise;

    always_comb begin
        sclk_rise = sclk_s && !sclk_d;
        sclk_fall = !sclk_s && sclk_d;
        restart_rise = restart_s && !restart_d;
        ov_rise = ov_s && !ov_d;
        next_sclk_d = sclk_s;
        next_ov_d = ov_s;
        next_restart_d = restart_s;
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_rx = rx;
        next_tx = tx;
        next_ctrl = ctrl;
        next_ov_flag = ov_flag;
        next_restart_req = 1'b0;
        next_soft_rst = 1'b0;
        next_rst_out_n = rst_out_n;
        next_soft_cnt = soft_cnt;
        next_sdo = sdo;
        next_sdo_oe = !csn_s;
        frame = {sdi_s, rx[15:1]};
        f_addr = frame[smr_pkg::ADDR_BITS-1:0];
        f_write = frame[smr_pkg::RW_BIT];
        f_data = frame[smr_pkg::DATA_LSB +: smr_pkg::DATA_BITS];
        req_mode = f_data[smr_pkg::MODE_MSB:smr_pkg::MODE_LSB];
        case (state)
            SMR_IDLE: begin
                if (!csn_s) begin
                    next_state = SMR_SHIFT;
                    next_bit_cnt = 5'h00;
                    next_tx = {read_value(smr_pkg::MODE_SUPPLY_CONTROL_ADDR, ctrl), 8'h00};
                    next_sdo = 1'b0;
                end
            end
            SMR_SHIFT: begin
                if (csn_s) begin
                    next_state = SMR_IDLE;
                end else if (sclk_rise) begin
                    next_rx = frame;
                    next_bit_cnt = bit_cnt + 5'h01;
                    if (bit_cnt == 5'(smr_pkg::ADDR_BITS - 1)) begin
                        next_tx = {read_value(frame[15:9], ctrl), 8'h00};
                    end
                    if (bit_cnt == 5'(smr_pkg::FRAME_BITS - 1)) begin
                        next_state = SMR_DONE;
                        if (f_write && f_addr == smr_pkg::MODE_SUPPLY_CONTROL_ADDR) begin
                            next_ctrl = f_data;
                            if (ctrl[smr_pkg::MODE_MSB:smr_pkg::MODE_LSB] == smr_pkg::MODE_STOP
                                && req_mode == smr_pkg::MODE_SLEEP) begin
                                next_ctrl[smr_pkg::MODE_MSB:smr_pkg::MODE_LSB] = smr_pkg::MODE_STOP;
                            end
                            if (req_mode == smr_pkg::MODE_SOFT_RESET) begin
                                next_soft_rst = 1'b1;
                                next_soft_cnt = 8'(SOFT_RESET_CYCLES);
                                next_rst_out_n = soft_reset_output_mask_in;
                            end
                        end
                    end
                end else if (sclk_fall) begin
                    next_sdo = tx[bit_cnt[3:0]];
                end
            end
            SMR_DONE: begin
                if (csn_s) begin
                    next_state = SMR_IDLE;
                end
            end
            default: begin
                next_state = SMR_IDLE;
            end
        endcase
        if (soft_cnt != 8'h00) begin
            next_soft_cnt = soft_cnt - 8'h01;
            if (soft_cnt == 8'h01) begin
                next_rst_out_n = 1'b1;
                next_ctrl = smr_pkg::MODE_SUPPLY_CONTROL_RESET;
            end
        end
        if (ov_rise) begin
            next_ov_flag = 1'b1;
            next_restart_req = ctrl[smr_pkg::OV_REACT_BIT];
        end else if (main_overvoltage_flag_clear_in) begin
            next_ov_flag = 1'b0;
        end
        if (restart_rise) begin
            next_ctrl = (next_ctrl & smr_pkg::RESTART_KEEP_MASK);
            next_ctrl[smr_pkg::MODE_MSB:smr_pkg::MODE_LSB] = smr_pkg::MODE_NORMAL;
            next_ctrl[smr_pkg::SECOND_MSB:smr_pkg::SECOND_LSB] = smr_pkg::SECOND_OFF;
        end
        if (ot_s) begin
            next_ctrl[smr_pkg::SECOND_MSB:smr_pkg::SECOND_LSB] = smr_pkg::SECOND_OFF;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state <= SMR_IDLE;
            sclk_d <= 1'b0;
            ov_d <= 1'b0;
            restart_d <= 1'b0;
            bit_cnt <= 5'h00;
            rx <= 16'h0000;
            tx <= 16'h0000;
            ctrl <= smr_pkg::MODE_SUPPLY_CONTROL_RESET;
            ov_flag <= 1'b0;
            restart_req <= 1'b0;
            soft_rst <= 1'b0;
            rst_out_n <= 1'b1;
            soft_cnt <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            state <= next_state;
            sclk_d <= next_sclk_d;
            ov_d <= next_ov_d;
            restart_d <= next_restart_d;
            bit_cnt <= next_bit_cnt;
            rx <= next_rx;
            tx <= next_tx;
            ctrl <= next_ctrl;
            ov_flag <= next_ov_flag;
            restart_req <= next_restart_req;
            soft_rst <= next_soft_rst;
            rst_out_n <= next_rst_out_n;
            soft_cnt <= next_soft_cnt;
            sdo <= next_sdo;
            sdo_oe <= next_sdo_oe;
        end
    end

    always_comb begin
        sdo_out = sdo;
        sdo_oe_out = sdo_oe;
        mode_out = ctrl[smr_pkg::MODE_MSB:smr_pkg::MODE_LSB];
        third_regulator_enable_out = ctrl[smr_pkg::THIRD_REG_BIT];
        second_regulator_select_out = ctrl[smr_pkg::SECOND_MSB:smr_pkg::SECOND_LSB];
        overvoltage_reaction_enable_out = ctrl[smr_pkg::OV_REACT_BIT];
        reset_threshold_select_out = ctrl[smr_pkg::THRESH_MSB:smr_pkg::THRESH_LSB];
        main_overvoltage_flag_out = ov_flag;
        restart_request_out = restart_req;
        soft_reset_out = soft_rst;
        reset_output_n_out = rst_out_n;
    end

    a_read_keeps: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == SMR_SHIFT && sclk_rise && bit_cnt == 5'h0f && !frame[7] && !restart_rise && !ot_s
         && soft_cnt == 8'h00) |=> ctrl == $past(ctrl))
        else $error("Read changed the register");
    a_write_store: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == SMR_SHIFT && sclk_rise && bit_cnt == 5'h0f && frame[7] && frame[6:0] == 7'h01
         && !(frame[15:14] == 2'h1 && ctrl[7:6] == 2'h2) && !restart_rise && !ot_s && soft_cnt == 8'h00)
        |=> ctrl == $past(frame[15:8]))
        else $error("Write not stored");
    a_stop_sleep: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (mode_out == 2'h2 && !restart_rise && soft_cnt == 8'h00) |=> mode_out != 2'h1)
        else $error("Stop to sleep accepted");
    a_restart_clr: assert property (@(posedge clk_in) disable iff (!rstn_in)
        restart_rise |=> mode_out == 2'h0 && second_regulator_select_out == 2'h0)
        else $error("Restart did not clear fields");
    a_restart_keep: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (restart_rise && soft_cnt == 8'h00 && !ot_s && !(state == SMR_SHIFT && sclk_rise))
        |=> ctrl == ($past(ctrl) & smr_pkg::RESTART_KEEP_MASK))
        else $error("Restart value wrong");
    a_ot_off: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ot_s |=> second_regulator_select_out == 2'h0)
        else $error("Overtemperature did not force off");
    a_ov_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
        ov_rise |=> main_overvoltage_flag_out && (restart_request_out == $past(ctrl[2])))
        else $error("Overvoltage reaction wrong");
    a_ov_sticky: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (main_overvoltage_flag_out && !main_overvoltage_flag_clear_in) |=> main_overvoltage_flag_out)
        else $error("Overvoltage flag lost");
    a_soft_ro: assert property (@(posedge clk_in) disable iff (!rstn_in)
        $rose(soft_reset_out) |-> reset_output_n_out == $past(soft_reset_output_mask_in))
        else $error("Reset output wrong on soft reset");
    a_soft_reload: assert property (@(posedge clk_in) disable iff (!rstn_in)
        soft_cnt == 8'h01 |=> ctrl == smr_pkg::MODE_SUPPLY_CONTROL_RESET && reset_output_n_out)
        else $error("Soft reset did not reload");
    a_unmapped_zero: assert property (@(posedge clk_in) disable iff (!rstn_in)
        (state == SMR_SHIFT && sclk_rise && bit_cnt == 5'h06 && frame[15:9] != 7'h01) |=> tx == 16'h0000)
        else $error("Unmapped read not zero");
    c_write: cover property (@(posedge clk_in) disable iff (!rstn_in) $changed(ctrl));
    c_soft: cover property (@(posedge clk_in) disable iff (!rstn_in) $rose(soft_reset_out));
    c_restart: cover property (@(posedge clk_in) disable iff (!rstn_in) restart_rise);
    c_stop_sleep: cover property (@(posedge clk_in) disable iff (!rstn_in)
        state == SMR_SHIFT && sclk_rise && bit_cnt == 5'h0f && frame[7] && ctrl[7:6] == 2'h2 && frame[15:14] == 2'h1);
endmodule : smr_regs

// File: design/smr_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain.
`timescale 1ns/1ps
module smr_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage;
    logic [WIDTH-1:0] next_stage;
    logic [WIDTH-1:0] next_sync;

    always_comb begin
        next_stage = async_in;
        next_sync = stage;
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stage <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            stage <= next_stage;
            sync_out <= next_sync;
        end
    end
endmodule : smr_sync

// File: inc/smr_pkg.sv
// Shared constants for the serial mode and supply register block.
package smr_pkg;
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned ADDR_BITS = 7;
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned RW_BIT = 7;
    localparam int unsigned DATA_LSB = 8;
    localparam logic [6:0] MODE_SUPPLY_CONTROL_ADDR = 7'h01;
    localparam logic [7:0] MODE_SUPPLY_CONTROL_RESET = 8'h00;
    localparam logic [7:0] RESTART_KEEP_MASK = 8'h23;
    localparam int unsigned MODE_MSB = 7;
    localparam int unsigned MODE_LSB = 6;
    localparam int unsigned THIRD_REG_BIT = 5;
    localparam int unsigned SECOND_MSB = 4;
    localparam int unsigned SECOND_LSB = 3;
    localparam int unsigned OV_REACT_BIT = 2;
    localparam int unsigned THRESH_MSB = 1;
    localparam int unsigned THRESH_LSB = 0;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_SOFT_RESET = 2'h3;
    localparam logic [1:0] SECOND_OFF = 2'h0;
    localparam logic [1:0] SECOND_NORMAL = 2'h1;
    localparam logic [1:0] SECOND_NORMAL_STOP = 2'h2;
    localparam logic [1:0] SECOND_ALWAYS = 2'h3;
    localparam logic [7:0] READ_ZERO = 8'h00;
endpackage : smr_pkg

// File: verif/smr_host.sv
// Host master model that frames commands on the serial port.
`timescale 1ns/1ps
module smr_host (
    input wire logic clk_in,
    input wire logic sdo_in,
    output logic sclk_out,
    output logic csn_out,
    output logic sdi_out
);
    initial begin
        sclk_out = 1'b0;
        csn_out = 1'b1;
        sdi_out = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
    endtask : wait_clk

    // Sends one frame, bit 0 first; the serial clock idles low between frames.
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        @(posedge clk_in);
        csn_out <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            wait_clk(6);
            sdi_out <= tx[i];
            wait_clk(6);
            sclk_out <= 1'b1;
            rx[i] = sdo_in;
            wait_clk(13);
            sclk_out <= 1'b0;
        end
        wait_clk(13);
        csn_out <= 1'b1;
        sdi_out <= ~tx[15];
        wait_clk(8);
    endtask : xfer
endmodule : smr_host

// File: verif/test_smr_regs.sv
// Self-checking bench for the serial mode and supply register block.
`timescale 1ns/1ps
module test_smr_regs;
    localparam int unsigned SR_CYCLES = 4;
    localparam int unsigned FRAME_CLKS = 413;
    logic clk_in, rstn_in, sclk, csn, sdi, sdo, sdo_oe;
    logic restart_in, ov_in, ot_in, mask_in, clr_in;
    logic [1:0] mode, second, thresh;
    logic third, react, flag, rreq, srst, ron;
    logic [15:0] rx;
    logic sdo_bus;
    int errors = 0;
    int num_checks = 0;
    int low_cnt = 0;
    int req_cnt = 0;
    int sr_cnt = 0;
    int oe_cnt = 0;
    int b0, b1, b2;

    // A released output line shows the inverse of its last bit, so a read outside the enable fails.
    assign sdo_bus = sdo_oe ? sdo : !sdo;

    smr_host host_u (.clk_in(clk_in), .sdo_in(sdo_bus), .sclk_out(sclk), .csn_out(csn), .sdi_out(sdi));

    smr_regs #(.SOFT_RESET_CYCLES(SR_CYCLES)) dut_u (
        .clk_in(clk_in), .rstn_in(rstn_in), .sclk_in(sclk), .csn_in(csn), .sdi_in(sdi),
        .sdo_out(sdo), .sdo_oe_out(sdo_oe), .restart_in(restart_in), .overvoltage_in(ov_in),
        .overtemperature_in(ot_in), .soft_reset_output_mask_in(mask_in),
        .main_overvoltage_flag_clear_in(clr_in), .mode_out(mode), .third_regulator_enable_out(third),
        .second_regulator_select_out(second), .overvoltage_reaction_enable_out(react),
        .reset_threshold_select_out(thresh), .main_overvoltage_flag_out(flag),
        .restart_request_out(rreq), .soft_reset_out(srst), .reset_output_n_out(ron)
    );

    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    always @(posedge clk_in) begin
        if (ron === 1'b0) low_cnt <= low_cnt + 1;
        if (rreq === 1'b1) req_cnt <= req_cnt + 1;
        if (srst === 1'b1) sr_cnt <= sr_cnt + 1;
        if (sdo_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic logic [7:0] fields();
        return {mode, third, second, react, thresh};
    endfunction : fields

    task automatic wr(input logic [6:0] addr, input logic [7:0] d);
        host_u.xfer({d, 1'b1, addr}, rx);
    endtask : wr

    task automatic rd(input logic [6:0] addr);
        host_u.xfer({8'h00, 1'b0, addr}, rx);
    endtask : rd

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_in);
    endtask : wait_clk

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test

    initial begin
        #100000;
        errors++;
        finish_test();
    end

    initial begin
        rstn_in = 1'b0;
        restart_in = 1'b0;
        ov_in = 1'b0;
        ot_in = 1'b0;
        mask_in = 1'b0;
        clr_in = 1'b0;
        wait_clk(16);
        rstn_in <= 1'b1;
        wait_clk(4);
        check(fields(), 16'h0000);
        check(ron, 16'h0001);
        check(sdo_oe, 16'h0000);
        check(oe_cnt, 16'h0000);
        rd(7'h01);
        check(rx[15:8], 16'h0000);
        check(oe_cnt, FRAME_CLKS);
        $display("Test reset values done");
        wr(7'h01, 8'h95);
        check(rx[15:8], 16'h0000);
        check(fields(), 16'h0095);
        rd(7'h01);
        check(rx[15:8], 16'h0095);
        check(fields(), 16'h0095);
        $display("Test write and read done");
        wr(7'h01, 8'h7a);
        check(rx[15:8], 16'h0095);
        check(fields(), 16'h00ba);
        wr(7'h05, 8'hff);
        rd(7'h05);
        check(rx[15:8], 16'h0000);
        check(fields(), 16'h00ba);
        $display("Test refused commands done");
        restart_in <= 1'b1;
        wait_clk(10);
        restart_in <= 1'b0;
        wait_clk(10);
        check(fields(), 16'h0022);
        $display("Test restart done");
        wr(7'h01, 8'h41);
        check(fields(), 16'h0041);
        wr(7'h01, 8'h04);
        b0 = req_cnt;
        ov_in <= 1'b1;
        wait_clk(10);
        ov_in <= 1'b0;
        wait_clk(10);
        check(flag, 16'h0001);
        check(req_cnt - b0, 16'h0001);
        clr_in <= 1'b1;
        wait_clk(1);
        clr_in <= 1'b0;
        wait_clk(3);
        check(flag, 16'h0000);
        wr(7'h01, 8'h00);
        b0 = req_cnt;
        ov_in <= 1'b1;
        wait_clk(10);
        ov_in <= 1'b0;
        wait_clk(10);
        check(flag, 16'h0001);
        check(req_cnt - b0, 16'h0000);
        $display("Test overvoltage done");
        wr(7'h01, 8'h18);
        ot_in <= 1'b1;
        wait_clk(10);
        check(fields(), 16'h0000);
        ot_in <= 1'b0;
        $display("Test overtemperature done");
        wr(7'h01, 8'h2b);
        check(fields(), 16'h002b);
        rstn_in <= 1'b0;
        wait_clk(4);
        rstn_in <= 1'b1;
        wait_clk(4);
        check(fields(), 16'h0000);
        check(flag, 16'h0000);
        $display("Test chip reset done");
        b1 = low_cnt;
        b2 = sr_cnt;
        wr(7'h01, 8'hc0);
        wait_clk(20);
        check(low_cnt - b1, SR_CYCLES);
        check(sr_cnt - b2, 16'h0001);
        check(fields(), 16'h0000);
        mask_in <= 1'b1;
        b1 = low_cnt;
        b2 = sr_cnt;
        wr(7'h01, 8'hc0);
        wait_clk(20);
        check(low_cnt - b1, 16'h0000);
        check(sr_cnt - b2, 16'h0001);
        $display("Test soft reset done");
        finish_test();
    end
endmodule : test_smr_regs
